/* src/igr_pkg.sv */
/*
 * igr_pkg: constants for the input gain-ranging control block.
 * Assumes a 32-bit APB master with byte addresses on an 8-bit paddr.
 */
package igr_pkg;
    localparam int          NPORT        = 2;
    localparam int          MANT_W       = 16;
    localparam int          CODE_W       = 3;
    localparam int          THR_W        = 10;
    localparam int          DWELL_W      = 20;
    localparam int          DLY_W        = 6;
    localparam int          DEPTH        = 64;
    localparam int          ADDR_W       = 8;

    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_STATUS  = 8'h04;
    localparam logic [3:0]  PAGE_PORT_A  = 4'h1;
    localparam logic [3:0]  PAGE_PORT_B  = 4'h2;
    localparam logic [3:0]  OFS_UPPER    = 4'h0;
    localparam logic [3:0]  OFS_LOWER    = 4'h4;
    localparam logic [3:0]  OFS_DWELL    = 4'h8;
    localparam logic [3:0]  OFS_DELAY    = 4'hC;

    localparam int          CTRL_EN_A    = 0;
    localparam int          CTRL_EN_B    = 1;
    localparam int          CTRL_CPLX    = 2;
    localparam int          ST_CODE_B    = 3;
    localparam int          ST_BUSY_A    = 6;
    localparam int          ST_BUSY_B    = 7;
    localparam int          ST_DWELL_A   = 8;
    localparam int          ST_DWELL_B   = 9;

    localparam logic [2:0]  RST_CTRL     = 3'h0;
    localparam logic [9:0]  RST_UPPER    = 10'h3FF;
    localparam logic [9:0]  RST_LOWER    = 10'h000;
    localparam logic [19:0] RST_DWELL    = 20'h00001;
    localparam logic [5:0]  RST_DELAY    = 6'h00;
    localparam logic [2:0]  CODE_MIN     = 3'h0;
    localparam logic [2:0]  CODE_MAX     = 3'h7;
endpackage : igr_pkg

/* src/igr_exp_delay.sv */
/*
 * igr_exp_delay: circular store of gain codes, read back a programmable
 * number of sample advances later. Runs on pclk; adv is a one-cycle pulse.
 */
`timescale 1ns/100ps
`default_nettype none
module igr_exp_delay
    import igr_pkg::*;
(
    input  wire logic              clk,      // system clock
    input  wire logic              rst_n,    // async reset, active low
    input  wire logic              adv,      // one sample taken
    input  wire logic [CODE_W-1:0] wr_code,  // code to store
    input  wire logic [DLY_W-1:0]  dly,      // delay in samples
    output logic      [CODE_W-1:0] rd_code   // delayed code, registered
);
    typedef struct packed {
        logic [DEPTH-1:0][CODE_W-1:0] mem;
        logic [DLY_W-1:0]             wp;
        logic [CODE_W-1:0]            rd;
    } igr_dly_s;

    igr_dly_s s_q;
    igr_dly_s s_d;

    always_comb
    begin
        s_d = s_q;
        if (adv)
        begin
            s_d.mem[s_q.wp] = wr_code;
            s_d.wp          = s_q.wp + 6'h01;
            // zero delay must bypass, the slot is being overwritten
            s_d.rd = (dly == RST_DELAY) ? wr_code : s_q.mem[s_q.wp - dly];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign rd_code = s_q.rd;
endmodule : igr_exp_delay
`default_nettype wire

/* src/igr_gain_ctrl.sv */
/*
 * igr_gain_ctrl: gain-ranging control and relinearization for input
 * ports A and B, with an APB register slave.
 * Assumes sample clocks and data come from pins (synchronised here) and
 * that the external tristate wire is resolved from the oe outputs.
 */
// Function
// - enable bit per port turns exponent pins into gain-code outputs, else inputs.
// - after reset all exponent pins are inputs, never driven.
// - magnitude above upper threshold lowers gain code by one at once.
// - magnitude below lower threshold loads the dwell counter from 20-bit value.
// - dwell counts down per sample while below; at one gain rises.
// - rising above lower threshold cancels pending rise, comparison restarts.
// - each code step attenuates incoming data 6.02 dB, one right shift.
// - programmable 6-bit sample delay between gain code and relinearizing exponent.
// - gain changes requested while relinearization delay runs are ignored.
// - thresholds compare against top ten bits of absolute sample magnitude.
// - on enabling, gain code starts at 000 before normal operation.
// - complex pairing shuts port B logic; its exponent follows port A.
// - exponent is unsigned binary, mantissa is twos complement.
`timescale 1ns/100ps
`default_nettype none
module igr_gain_ctrl
    import igr_pkg::*;
(
    input  wire logic              pclk,                        // 200 MHz
    input  wire logic              presetn,                     // async, low
    input  wire logic              psel,                        // apb select
    input  wire logic              penable,                     // apb enable
    input  wire logic              pwrite,                      // apb write
    input  wire logic [ADDR_W-1:0] paddr,                       // byte address
    input  wire logic [31:0]       pwdata,                      // write data
    output logic      [31:0]       prdata,                      // read data
    output logic                   pready,                      // apb ready
    output logic                   pslverr,                     // unmapped
    input  wire logic              port_a_sample_clock,         // port a clock
    input  wire logic [MANT_W-1:0] port_a_data,                 // port a mantissa
    input  wire logic [CODE_W-1:0] port_a_exponent_gain_pins_in,  // pin level
    output logic      [CODE_W-1:0] port_a_exponent_gain_pins_out, // gain code
    output logic                   port_a_exponent_gain_pins_oe,  // drive
    input  wire logic              port_b_sample_clock,         // port b clock
    input  wire logic [MANT_W-1:0] port_b_data,                 // port b mantissa
    input  wire logic [CODE_W-1:0] port_b_exponent_gain_pins_in,  // pin level
    output logic      [CODE_W-1:0] port_b_exponent_gain_pins_out, // gain code
    output logic                   port_b_exponent_gain_pins_oe,  // drive
    output logic      [MANT_W-1:0] port_a_relin_data,           // scaled data
    output logic                   port_a_relin_valid,          // one per sample
    output logic      [MANT_W-1:0] port_b_relin_data,           // scaled data
    output logic                   port_b_relin_valid           // one per sample
);
    typedef struct packed {
        logic [NPORT-1:0]                    ck_s1;
        logic [NPORT-1:0]                    ck_s2;
        logic [NPORT-1:0]                    ck_s3;
        logic [NPORT-1:0][MANT_W-1:0]        dat_s1;
        logic [NPORT-1:0][MANT_W-1:0]        dat_s2;
        logic [NPORT-1:0][CODE_W-1:0]        exp_s1;
        logic [NPORT-1:0][CODE_W-1:0]        exp_s2;
        logic [NPORT-1:0]                    en_prev;
        logic [NPORT-1:0]                    oe;
        logic [NPORT-1:0][CODE_W-1:0]        code;
        logic [NPORT-1:0][DWELL_W-1:0]       dwell;
        logic [NPORT-1:0][DLY_W-1:0]         busy;
        logic [NPORT-1:0][MANT_W-1:0]        relin;
        logic [NPORT-1:0]                    vld;
        logic [2:0]                          ctrl;
        logic [NPORT-1:0][THR_W-1:0]         upper;
        logic [NPORT-1:0][THR_W-1:0]         lower;
        logic [NPORT-1:0][DWELL_W-1:0]       dwell_val;
        logic [NPORT-1:0][DLY_W-1:0]         dly;
        logic                                pready;
        logic                                pslverr;
        logic [31:0]                         prdata;
    } igr_state_s;

    igr_state_s                   st_q;
    igr_state_s                   st_d;
    logic [NPORT-1:0]             en_eff;
    logic [NPORT-1:0]             stb;
    logic [NPORT-1:0][CODE_W-1:0] dly_code;
    logic [NPORT-1:0][CODE_W-1:0] exp_eff;
    logic [NPORT-1:0][THR_W-1:0]  mag;
    logic                         hit;
    logic [31:0]                  rdata;
    logic                         port_sel;

    // top ten bits of |x|; -32768 clips to full scale so abs never wraps
    function automatic logic [THR_W-1:0] mag10(input logic [MANT_W-1:0] d);
        logic [MANT_W-1:0] a;
        a = d[MANT_W-1] ? (~d + 16'h0001) : d;
        if (a[MANT_W-1])
            a = 16'h7FFF;
        return a[MANT_W-2:MANT_W-2-THR_W+1];
    endfunction : mag10

    assign en_eff[0] = st_q.ctrl[CTRL_EN_A];
    assign en_eff[1] = st_q.ctrl[CTRL_EN_B] & ~st_q.ctrl[CTRL_CPLX];

    genvar g;
    generate
        for (g = 0; g < NPORT; g++)
        begin : g_port
            assign stb[g] = st_q.ck_s2[g] & ~st_q.ck_s3[g];
            assign mag[g] = mag10(st_q.dat_s2[g]);
            igr_exp_delay u_delay (
                .clk     (pclk),
                .rst_n   (presetn),
                .adv     (stb[g]),
                .wr_code (st_q.code[g]),
                .dly     (st_q.dly[g]),
                .rd_code (dly_code[g])
            );
        end
    endgenerate

    // relinearizing exponent: delayed own code, pin input, or port a's in pairing
    assign exp_eff[0] = en_eff[0] ? dly_code[0] : st_q.exp_s2[0];
    assign exp_eff[1] = st_q.ctrl[CTRL_CPLX] ? exp_eff[0]
                      : (en_eff[1] ? dly_code[1] : st_q.exp_s2[1]);

    // register decode
    always_comb
    begin
        hit      = 1'b1;
        rdata    = 32'h0000_0000;
        port_sel = (paddr[7:4] == PAGE_PORT_B);
        if (paddr == ADDR_CTRL)
            rdata[2:0] = st_q.ctrl;
        else if (paddr == ADDR_STATUS)
        begin
            rdata[CODE_W-1:0]                 = st_q.code[0];
            rdata[ST_CODE_B+CODE_W-1:ST_CODE_B] = st_q.code[1];
            rdata[ST_BUSY_A]                  = (st_q.busy[0] != RST_DELAY);
            rdata[ST_BUSY_B]                  = (st_q.busy[1] != RST_DELAY);
            rdata[ST_DWELL_A]                 = (st_q.dwell[0] != 20'h00000);
            rdata[ST_DWELL_B]                 = (st_q.dwell[1] != 20'h00000);
        end
        else if ((paddr[7:4] == PAGE_PORT_A || port_sel) && paddr[3:0] == OFS_UPPER)
            rdata[THR_W-1:0] = st_q.upper[port_sel];
        else if ((paddr[7:4] == PAGE_PORT_A || port_sel) && paddr[3:0] == OFS_LOWER)
            rdata[THR_W-1:0] = st_q.lower[port_sel];
        else if ((paddr[7:4] == PAGE_PORT_A || port_sel) && paddr[3:0] == OFS_DWELL)
            rdata[DWELL_W-1:0] = st_q.dwell_val[port_sel];
        else if ((paddr[7:4] == PAGE_PORT_A || port_sel) && paddr[3:0] == OFS_DELAY)
            rdata[DLY_W-1:0] = st_q.dly[port_sel];
        else
            hit = 1'b0;
    end

    always_comb
    begin
        st_d         = st_q;
        st_d.pready  = 1'b0;
        st_d.pslverr = 1'b0;
        st_d.ck_s1   = {port_b_sample_clock, port_a_sample_clock};
        st_d.ck_s2   = st_q.ck_s1;
        st_d.ck_s3   = st_q.ck_s2;
        st_d.dat_s1  = {port_b_data, port_a_data};
        st_d.dat_s2  = st_q.dat_s1;
        st_d.exp_s1  = {port_b_exponent_gain_pins_in, port_a_exponent_gain_pins_in};
        st_d.exp_s2  = st_q.exp_s1;

        // one wait state: answer prepared in the first access cycle
        if (psel && penable && !st_q.pready)
        begin
            st_d.pready  = 1'b1;
            st_d.prdata  = rdata;
            st_d.pslverr = ~hit;
        end
        // status is read-only; its offset would otherwise alias port a's lower threshold
        if (psel && penable && st_q.pready && pwrite && hit && paddr != ADDR_STATUS)
        begin
            if (paddr == ADDR_CTRL)
                st_d.ctrl = pwdata[2:0];
            else if (paddr[3:0] == OFS_UPPER)
                st_d.upper[port_sel] = pwdata[THR_W-1:0];
            else if (paddr[3:0] == OFS_LOWER)
                st_d.lower[port_sel] = pwdata[THR_W-1:0];
            else if (paddr[3:0] == OFS_DWELL)
                st_d.dwell_val[port_sel] = pwdata[DWELL_W-1:0];
            else if (paddr[3:0] == OFS_DELAY)
                st_d.dly[port_sel] = pwdata[DLY_W-1:0];
        end

        for (int p = 0; p < NPORT; p++)
        begin
            st_d.oe[p]      = en_eff[p];
            st_d.en_prev[p] = en_eff[p];
            st_d.vld[p]     = stb[p];
            // code, dwell and busy are cleared while disabled and in the first enabled cycle
            if (!en_eff[p] || !st_q.en_prev[p])
            begin
                st_d.code[p]  = CODE_MIN;
                st_d.dwell[p] = 20'h00000;
                st_d.busy[p]  = RST_DELAY;
            end
            else if (stb[p])
            begin
                if (st_q.busy[p] != RST_DELAY)
                    st_d.busy[p] = st_q.busy[p] - 6'h01;
                if (mag[p] > st_q.upper[p])
                begin
                    st_d.dwell[p] = 20'h00000;
                    // no dwell on the way down: overflow is the worse failure
                    if (st_q.busy[p] == RST_DELAY && st_q.code[p] != CODE_MIN)
                    begin
                        st_d.code[p] = st_q.code[p] - 3'h1;
                        st_d.busy[p] = st_q.dly[p];
                    end
                end
                else if (mag[p] < st_q.lower[p])
                begin
                    if (st_q.dwell[p] == 20'h00000)
                        // zero dwell behaves as one sample
                        st_d.dwell[p] = (st_q.dwell_val[p] == 20'h00000) ? RST_DWELL
                                      : st_q.dwell_val[p];
                    else if (st_q.dwell[p] == RST_DWELL)
                    begin
                        st_d.dwell[p] = 20'h00000;
                        if (st_q.busy[p] == RST_DELAY && st_q.code[p] != CODE_MAX)
                        begin
                            st_d.code[p] = st_q.code[p] + 3'h1;
                            st_d.busy[p] = st_q.dly[p];
                        end
                    end
                    else
                        st_d.dwell[p] = st_q.dwell[p] - 20'h00001;
                end
                else
                    st_d.dwell[p] = 20'h00000;
            end
            if (stb[p])
                st_d.relin[p] = MANT_W'($signed(st_q.dat_s2[p]) >>> exp_eff[p]);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q           <= '0;
            st_q.ctrl      <= RST_CTRL;
            st_q.upper     <= {RST_UPPER, RST_UPPER};
            st_q.lower     <= {RST_LOWER, RST_LOWER};
            st_q.dwell_val <= {RST_DWELL, RST_DWELL};
            st_q.dly       <= {RST_DELAY, RST_DELAY};
        end
        else
            st_q <= st_d;
    end

    assign prdata                        = st_q.prdata;
    assign pready                        = st_q.pready;
    assign pslverr                       = st_q.pslverr;
    assign port_a_exponent_gain_pins_out = st_q.code[0];
    assign port_a_exponent_gain_pins_oe  = st_q.oe[0];
    assign port_b_exponent_gain_pins_out = st_q.code[1];
    assign port_b_exponent_gain_pins_oe  = st_q.oe[1];
    assign port_a_relin_data             = st_q.relin[0];
    assign port_a_relin_valid            = st_q.vld[0];
    assign port_b_relin_data             = st_q.relin[1];
    assign port_b_relin_valid            = st_q.vld[1];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    pins_follow_enable_a: assert property (
        !st_q.ctrl[CTRL_EN_A] |=> !port_a_exponent_gain_pins_oe)
        else $error("port a pins driven while disabled");
    enable_start_zero_a: assert property (
        en_eff[0] && !st_q.en_prev[0] |=> port_a_exponent_gain_pins_out == CODE_MIN)
        else $error("gain code not cleared on enable");
    fast_down_a: assert property (
        en_eff[0] && st_q.en_prev[0] && stb[0] && mag[0] > st_q.upper[0]
        && st_q.busy[0] == 6'h00 && st_q.code[0] != 3'h0
        |=> st_q.code[0] == $past(st_q.code[0]) - 3'h1)
        else $error("gain code not lowered at once");
    dwell_load_a: assert property (
        en_eff[0] && st_q.en_prev[0] && stb[0] && mag[0] < st_q.lower[0]
        && st_q.dwell[0] == 20'h00000 && st_q.dwell_val[0] > 20'h00001
        |=> st_q.dwell[0] == $past(st_q.dwell_val[0]))
        else $error("dwell counter not loaded");
    rise_after_dwell_a: assert property (
        st_q.code[0] != 3'h7 && st_q.dwell[0] != 20'h00001
        |=> st_q.code[0] <= $past(st_q.code[0]))
        else $error("gain rose before dwell expired");
    dwell_cancel_a: assert property (
        en_eff[0] && st_q.en_prev[0] && stb[0] && mag[0] >= st_q.lower[0]
        |=> st_q.dwell[0] == 20'h00000)
        else $error("pending rise not cancelled");
    busy_freeze_a: assert property (
        en_eff[0] && st_q.en_prev[0] && st_q.busy[0] != 6'h00 |=> $stable(st_q.code[0]))
        else $error("gain changed during relinearization");
    code_saturate_a: assert property (
        st_q.code[0] == 3'h7 |=> st_q.code[0] inside {3'h7, 3'h6, 3'h0})
        else $error("gain code wrapped at top");
    pair_b_off_a: assert property (st_q.ctrl[CTRL_CPLX] |=> !st_q.oe[1] && st_q.code[1] == 3'h0)
        else $error("port b gain logic active in pairing");
    relin_shift_a: assert property (
        stb[0] && !en_eff[0] |=> port_a_relin_data
            == MANT_W'($signed($past(st_q.dat_s2[0])) >>> $past(st_q.exp_s2[0])))
        else $error("relinearized data wrong");
    apb_ready_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not one wait state");

    gain_down_c: cover property (st_q.code[0] == 3'h2 ##1 st_q.code[0] == 3'h1);
    gain_up_c: cover property (st_q.dwell[0] == 20'h00001 ##1 st_q.code[0] == 3'h1);
    pair_c: cover property (st_q.ctrl[CTRL_CPLX] && en_eff[0] && port_b_relin_valid);
endmodule : igr_gain_ctrl
`default_nettype wire

/* verif/igr_far_side.sv */
/*
 * igr_far_side: one port's converter side, sample clock, mantissa, exponent.
 * Assumes the bench calls send() just after a pclk rising edge.
 */
`timescale 1ns/100ps
`default_nettype none
module igr_far_side
    import igr_pkg::*;
(
    input  wire logic              pclk,     // system clock
    input  wire logic [CODE_W-1:0] code,     // gain code from block
    input  wire logic              oe,       // block drives the pins
    output logic                   smp_clk,  // sample clock, idles low
    output logic      [MANT_W-1:0] data,     // mantissa
    output logic      [CODE_W-1:0] pin_lvl   // resolved exponent wire
);
    logic [CODE_W-1:0] adc_exp;

    initial
    begin
        smp_clk = 1'b0;
        data    = '0;
        adc_exp = '0;
    end

    // block owns the wire while it drives, else the converter's exponent
    assign pin_lvl = oe ? code : adc_exp;

    task automatic send(input logic [MANT_W-1:0] d, input logic [CODE_W-1:0] e);
        data    <= d;
        adc_exp <= e;
        repeat (3) @(posedge pclk);
        smp_clk <= 1'b1;
        repeat (4) @(posedge pclk);
        smp_clk <= 1'b0;
        repeat (2) @(posedge pclk);
        // hold time over: show the inverse so a late capture is caught
        data <= ~d;
        repeat (2) @(posedge pclk);
    endtask : send
endmodule : igr_far_side
`default_nettype wire

/* verif/input_gain_ranging_control_tb_top.sv */
/*
 * input_gain_ranging_control_tb_top: apb setup, sample traffic on both
 * ports, integer model of the gain loop. Assumes igr_pkg and igr_far_side.
 */
`timescale 1ns/100ps
`default_nettype none
module input_gain_ranging_control_tb_top
    import igr_pkg::*;
;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata;
    logic              clk_a, clk_b, oe_a, oe_b, vld_a, vld_b;
    logic [MANT_W-1:0] dat_a, dat_b, rel_a, rel_b, got_a, got_b;
    logic [CODE_W-1:0] pin_a, pin_b, out_a, out_b;
    int                error_cnt, compares, cyc, n_a, n_b, seed_v;
    int                code, dw, busy, stab, en, up, lo, dwell, dly;
    int                gain_seq[12] = '{0, 1, 1, 1, 1, 1, 1, 2, 1, 1, 1, 1};

    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;

    igr_gain_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_a_sample_clock(clk_a), .port_a_data(dat_a),
        .port_a_exponent_gain_pins_in(pin_a), .port_a_exponent_gain_pins_out(out_a),
        .port_a_exponent_gain_pins_oe(oe_a), .port_b_sample_clock(clk_b),
        .port_b_data(dat_b), .port_b_exponent_gain_pins_in(pin_b),
        .port_b_exponent_gain_pins_out(out_b), .port_b_exponent_gain_pins_oe(oe_b),
        .port_a_relin_data(rel_a), .port_a_relin_valid(vld_a),
        .port_b_relin_data(rel_b), .port_b_relin_valid(vld_b));
    igr_far_side far_a (.pclk(pclk), .code(out_a), .oe(oe_a), .smp_clk(clk_a),
        .data(dat_a), .pin_lvl(pin_a));
    igr_far_side far_b (.pclk(pclk), .code(out_b), .oe(oe_b), .smp_clk(clk_b),
        .data(dat_b), .pin_lvl(pin_b));

    always @(posedge pclk)
    begin
        if (vld_a === 1'b1)
        begin
            got_a <= rel_a;
            n_a   <= n_a + 1;
        end
        if (vld_b === 1'b1)
        begin
            got_b <= rel_b;
            n_b   <= n_b + 1;
        end
        cyc <= cyc + 1;
        // ceiling well above the ~2000 cycles the sequence needs
        if (cyc == 30000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // ready, data and error are taken at the rising edge that sees ready high
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        rd  = prdata;
        err = pslverr;
        if (n >= 50)
            error_cnt++;
        psel    <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never re-drives psel in this time step
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk({31'h0, e}, {31'h0, ee});
        chk(r, exp);
    endtask : rchk

    function automatic void step(input int d);
        int m;
        int b0;
        b0 = busy;
        m  = (d < 0) ? -d : d;
        m  = ((m > 32767) ? 32767 : m) >> 5;
        stab++;
        if (busy > 0)
            busy--;
        // thresholds and dwell keep running while a change settles; only the step is held
        if (m > up)
        begin
            dw = 0;
            if (b0 == 0 && code > 0)
            begin
                code--;
                busy = dly;
                stab = 0;
            end
        end
        else if (m >= lo)
            dw = 0;
        else if (dw == 0)
            dw = dwell;
        else if (dw > 1)
            dw--;
        else
        begin
            dw = 0;
            if (b0 == 0 && code < 7)
            begin
                code++;
                busy = dly;
                stab = 0;
            end
        end
    endfunction : step

    task automatic smp(input int p, input int kind, input int e);
        logic [MANT_W-1:0] d;
        int                k;
        int                x;
        k = (kind == 0) ? up + 1 : (kind == 1) ? lo - 1 : up;
        d = MANT_W'((k << 5) + int'($urandom % 32));
        if ($urandom % 2 == 1)
            d = -d;
        k = (p == 0) ? n_a : n_b;
        if (p == 0)
            far_a.send(d, CODE_W'(e));
        else
            far_b.send(d, CODE_W'(e));
        chk(((p == 0) ? n_a : n_b) - k, 32'h1);
        if (p == 0 && en == 1)
            step(int'($signed(d)));
        x = int'($signed(d)) >>> ((en == 1) ? code : e);
        if (en == 0 || stab > dly + 1)
            chk({16'h0, (p == 0) ? got_a : got_b}, {16'h0, x[15:0]});
        if (p == 0)
            chk({28'h0, oe_a, out_a}, {28'h0, 1'(en), CODE_W'(code)});
        else
            chk({28'h0, oe_b, out_b}, 32'h0);
    endtask : smp

    task automatic setup(input int dl);
        wr(ADDR_CTRL, 32'h0);
        dly = dl;
        wr({PAGE_PORT_A, OFS_UPPER}, 32'(up));
        wr({PAGE_PORT_A, OFS_LOWER}, 32'(lo));
        wr({PAGE_PORT_A, OFS_DWELL}, 32'(dwell));
        wr({PAGE_PORT_A, OFS_DELAY}, 32'(dly));
        rchk({PAGE_PORT_A, OFS_DELAY}, 32'(dly), 1'b0);
        wr(ADDR_STATUS, 32'hFFFF_FFFF);
        rchk({PAGE_PORT_A, OFS_LOWER}, 32'(lo), 1'b0);
        wr(ADDR_CTRL, 32'h1);
        en   = 1;
        code = 0;
        dw   = 0;
        busy = 0;
        stab = 0;
        repeat (2) @(posedge pclk);
        chk({28'h0, oe_a, out_a}, 32'h8);
    endtask : setup

    initial
    begin
        {error_cnt, compares, cyc, n_a, n_b, en, code, dw, busy, stab, dly} = '0;
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr  = '0;
        pwdata = '0;
        up     = 'h200;
        lo     = 'h40;
        dwell  = 3;
        seed_v = $urandom(34505);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({30'h0, oe_a, oe_b}, 32'h0);
        rchk(ADDR_CTRL, 32'h0, 1'b0);
        rchk({PAGE_PORT_A, OFS_UPPER}, {22'h0, RST_UPPER}, 1'b0);
        rchk({PAGE_PORT_A, OFS_DWELL}, {12'h0, RST_DWELL}, 1'b0);
        rchk(8'hFC, 32'h0, 1'b1);
        for (int i = 0; i < 8; i++)
            smp(0, $urandom % 3, i);
        setup(0);
        foreach (gain_seq[i])
            smp(0, gain_seq[i], 0);
        repeat (32) smp(0, 1, 0);
        repeat (2) smp(0, 0, 0);
        rchk(ADDR_STATUS, 32'(code), 1'b0);
        repeat (40) smp(0, $urandom % 3, 0);
        setup(3);
        repeat (60) smp(0, $urandom % 3, 0);
        wr(ADDR_CTRL, 32'h7);
        repeat (6) smp(0, 2, 0);
        repeat (6) smp(1, $urandom % 3, 0);
        give_verdict();
    end
endmodule : input_gain_ranging_control_tb_top
`default_nettype wire
